// file: pci_ctl_pkg.sv
package pci_ctl_pkg;

  // ----------------------------------------------------------------
  // Command register bits
  // ----------------------------------------------------------------
  localparam int PERR_ENABLE_BIT = 6;
  localparam int SERR_ENABLE_BIT = 8;

  // ----------------------------------------------------------------
  // Bus commands
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_MEM_READ = 4'h6;
  localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
  localparam logic [3:0] CMD_CFG_READ = 4'hA;
  localparam logic [3:0] CMD_CFG_WRITE = 4'hB;

  // ----------------------------------------------------------------
  // Timing and idle byte enables
  // ----------------------------------------------------------------
  localparam int ABORT_CLOCKS = 5;
  localparam logic [2:0] ABORT_COUNT = 3'h5;
  localparam logic [3:0] BYTE_EN_NONE = 4'hF;

endpackage

// file: pci_parity_gen.sv
module pci_parity_gen (
  // Bus lines
  input wire logic [31:0] ad_i,
  input wire logic [3:0] cbe_i,
  // Even parity bit
  output logic par_o
);
  assign par_o = ^{ad_i, cbe_i};
endmodule // pci_parity_gen

// file: pci_target_decode.sv
module pci_target_decode (
  // Address phase contents
  input wire logic [31:0] ad_i,
  input wire logic [3:0] cbe_i,
  input wire logic idsel_i,
  input wire logic [31:0] mem_base_i,
  input wire logic [31:0] mem_mask_i,
  // Decode result
  output logic hit_o,
  output logic is_write_o
);
  logic cfg_cmd;
  logic mem_cmd;
  assign cfg_cmd = (cbe_i == pci_ctl_pkg::CMD_CFG_READ) || (cbe_i == pci_ctl_pkg::CMD_CFG_WRITE);
  assign mem_cmd = (cbe_i == pci_ctl_pkg::CMD_MEM_READ) || (cbe_i == pci_ctl_pkg::CMD_MEM_WRITE);
  // Config cycles claimed only with select active
  assign hit_o = (cfg_cmd && idsel_i && (ad_i[1:0] == 2'h0)) ||
                 (mem_cmd && ((ad_i & mem_mask_i) == (mem_base_i & mem_mask_i)));
  assign is_write_o = cbe_i[0];
endmodule // pci_target_decode

// file: pci_bus_control.sv
module pci_bus_control #(
  parameter logic [31:0] MEM_BASE = 32'h0000_0000,
  parameter logic [31:0] MEM_MASK = 32'hFFFF_F000
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Address/data and command lines
  input wire logic [31:0] ad_i,
  output logic [31:0] ad_o,
  output logic ad_oe_o,
  input wire logic [3:0] cbe_i,
  output logic [3:0] cbe_o,
  output logic cbe_oe_o,
  input wire logic par_i,
  output logic par_o,
  output logic par_oe_o,
  // Handshake lines, active low
  input wire logic frame_n_i,
  output logic frame_n_o,
  output logic frame_oe_o,
  input wire logic irdy_n_i,
  output logic irdy_n_o,
  output logic irdy_oe_o,
  input wire logic trdy_n_i,
  output logic trdy_n_o,
  output logic trdy_oe_o,
  input wire logic devsel_n_i,
  output logic devsel_n_o,
  output logic devsel_oe_o,
  input wire logic stop_n_i,
  output logic stop_n_o,
  output logic stop_oe_o,
  output logic perr_n_o,
  output logic perr_oe_o,
  output logic serr_n_o,
  output logic serr_oe_o,
  // Arbitration and selection
  output logic req_n_o,
  input wire logic gnt_n_i,
  input wire logic idsel_i,
  // Command register enable bits
  input wire logic [15:0] command_i,
  // Error sources
  input wire logic sys_err_i,
  input wire logic card_addr_perr_i,
  // Initiator user side
  input wire logic mst_start_i,
  input wire logic [31:0] mst_addr_i,
  input wire logic [3:0] mst_cmd_i,
  input wire logic [31:0] mst_wdata_i,
  input wire logic [3:0] mst_be_n_i,
  output logic mst_busy_o,
  output logic mst_done_o,
  output logic mst_abort_o,
  output logic [31:0] mst_rdata_o,
  // Target user side
  input wire logic [31:0] tgt_rdata_i,
  output logic tgt_write_o,
  output logic [31:0] tgt_wdata_o,
  output logic [3:0] tgt_be_n_o,
  output logic [31:0] tgt_addr_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {IDLE, M_ADDR, M_DATA, M_TURN, T_CLAIM, T_DATA, T_TURN} bus_state_type;
  bus_state_type state;
  logic [2:0] wait_cnt;
  logic pending, mst_write, tgt_is_write, tgt_hit, dec_write, calc_par;
  logic par_check, serr_en, perr_en, bus_idle, data_done;

  assign perr_en = command_i[pci_ctl_pkg::PERR_ENABLE_BIT];
  assign serr_en = command_i[pci_ctl_pkg::SERR_ENABLE_BIT];
  assign bus_idle = frame_n_i && irdy_n_i;
  assign data_done = !irdy_n_i && !trdy_n_i;

  pci_target_decode u_decode (
    .ad_i(ad_i), .cbe_i(cbe_i), .idsel_i(idsel_i),
    .mem_base_i(MEM_BASE), .mem_mask_i(MEM_MASK), .hit_o(tgt_hit), .is_write_o(dec_write)
  );

  pci_parity_gen u_parity (
    .ad_i(ad_oe_o ? ad_o : ad_i), .cbe_i(cbe_oe_o ? cbe_o : cbe_i), .par_o(calc_par)
  );

  // ----------------------------------------------------------------
  // Request and sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pending <= 1'b0;
    end else if (mst_start_i) begin
      pending <= 1'b1;
    end else if (state == M_ADDR) begin
      pending <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      req_n_o <= 1'b1;
    end else begin
      req_n_o <= !(pending && state == IDLE);
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= IDLE;
      wait_cnt <= 3'h0;
      mst_write <= 1'b0;
      tgt_is_write <= 1'b0;
      mst_done_o <= 1'b0;
      mst_abort_o <= 1'b0;
      mst_rdata_o <= 32'h0000_0000;
      tgt_write_o <= 1'b0;
      tgt_wdata_o <= 32'h0000_0000;
      tgt_be_n_o <= pci_ctl_pkg::BYTE_EN_NONE;
      tgt_addr_o <= 32'h0000_0000;
    end else begin
      mst_done_o <= 1'b0;
      mst_abort_o <= 1'b0;
      tgt_write_o <= 1'b0;
      case (state)
        IDLE: begin
          if (!frame_n_i && tgt_hit) begin
            state <= T_CLAIM;
            tgt_is_write <= dec_write;
            tgt_addr_o <= ad_i;
          end else if (pending && !gnt_n_i && bus_idle) begin
            state <= M_ADDR;
            mst_write <= mst_cmd_i[0];
          end
        end
        M_ADDR: begin
          state <= M_DATA;
          wait_cnt <= 3'h1;
        end
        M_DATA: begin
          wait_cnt <= wait_cnt + 3'h1;
          if (data_done) begin
            state <= M_TURN;
            mst_done_o <= 1'b1;
            mst_rdata_o <= ad_i;
          end else if (!stop_n_i) begin
            state <= M_TURN;
            mst_abort_o <= 1'b1;
          end else if (devsel_n_i && wait_cnt == pci_ctl_pkg::ABORT_COUNT) begin
            state <= M_TURN;
            mst_abort_o <= 1'b1;
          end
        end
        M_TURN: state <= IDLE;
        T_CLAIM: state <= T_DATA;
        T_DATA: begin
          if (!irdy_n_i) begin
            state <= T_TURN;
            tgt_write_o <= tgt_is_write;
            tgt_wdata_o <= ad_i;
            tgt_be_n_o <= cbe_i;
          end
        end
        default: state <= IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      frame_n_o <= 1'b1;
      frame_oe_o <= 1'b0;
      irdy_n_o <= 1'b1;
      irdy_oe_o <= 1'b0;
      ad_o <= 32'h0000_0000;
      ad_oe_o <= 1'b0;
      cbe_o <= pci_ctl_pkg::BYTE_EN_NONE;
      cbe_oe_o <= 1'b0;
    end else begin
      if (state == IDLE && !gnt_n_i && bus_idle && !(!frame_n_i && tgt_hit)) begin
        // Parked or starting: drive AD and C/BE so they never float while granted
        ad_oe_o <= 1'b1;
        cbe_oe_o <= 1'b1;
        ad_o <= pending ? mst_addr_i : 32'h0000_0000;
        cbe_o <= pending ? mst_cmd_i : pci_ctl_pkg::BYTE_EN_NONE;
        frame_n_o <= !pending;
        frame_oe_o <= pending;
        irdy_oe_o <= pending;
        irdy_n_o <= 1'b1;
      end else if (state == M_ADDR) begin
        // Single data phase, so frame drops with irdy on
        frame_n_o <= 1'b1;
        irdy_n_o <= 1'b0;
        cbe_o <= mst_be_n_i;
        ad_o <= mst_wdata_i;
        ad_oe_o <= mst_write;
      end else if (state == M_DATA && (data_done || !stop_n_i ||
                   (devsel_n_i && wait_cnt == pci_ctl_pkg::ABORT_COUNT))) begin
        irdy_n_o <= 1'b1;
        ad_oe_o <= 1'b0;
        cbe_oe_o <= 1'b0;
      end else if (state == M_TURN || (state == IDLE && gnt_n_i)) begin
        frame_oe_o <= 1'b0;
        irdy_oe_o <= 1'b0;
        ad_oe_o <= 1'b0;
        cbe_oe_o <= 1'b0;
      end else if (state == T_CLAIM) begin
        ad_o <= tgt_rdata_i;
        ad_oe_o <= !tgt_is_write;
      end else if (state == T_DATA && !irdy_n_i) begin
        ad_oe_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      devsel_n_o <= 1'b1;
      devsel_oe_o <= 1'b0;
      trdy_n_o <= 1'b1;
      trdy_oe_o <= 1'b0;
      stop_n_o <= 1'b1;
      stop_oe_o <= 1'b0;
    end else begin
      stop_n_o <= 1'b1;
      if (state == IDLE && !frame_n_i && tgt_hit) begin
        devsel_n_o <= 1'b0;
        devsel_oe_o <= 1'b1;
        trdy_oe_o <= 1'b1;
        stop_oe_o <= 1'b1;
      end else if (state == T_CLAIM) begin
        trdy_n_o <= 1'b0;
      end else if (state == T_DATA && !irdy_n_i) begin
        devsel_n_o <= 1'b1;
        trdy_n_o <= 1'b1;
      end else if (state == T_TURN) begin
        devsel_oe_o <= 1'b0;
        trdy_oe_o <= 1'b0;
        stop_oe_o <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Parity and errors
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      par_o <= 1'b0;
      par_oe_o <= 1'b0;
      par_check <= 1'b0;
      perr_n_o <= 1'b1;
      perr_oe_o <= 1'b0;
      serr_n_o <= 1'b1;
      serr_oe_o <= 1'b0;
    end else begin
      par_o <= calc_par;
      par_oe_o <= ad_oe_o;
      par_check <= (state == T_DATA) && !irdy_n_i && tgt_is_write;
      perr_n_o <= !(par_check && perr_en && (par_o != par_i));
      perr_oe_o <= par_check && perr_en;
      serr_n_o <= !(serr_en && (sys_err_i || card_addr_perr_i));
      serr_oe_o <= serr_en && (sys_err_i || card_addr_perr_i);
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mst_busy_o <= 1'b0;
    end else begin
      mst_busy_o <= pending || (state inside {M_ADDR, M_DATA, M_TURN});
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_claim;
    state == IDLE && !frame_n_i && tgt_hit;
  endsequence
  sequence s_unclaimed;
    state == M_ADDR ##1 (devsel_n_i && trdy_n_i && stop_n_i) [*5];
  endsequence

  chk_claim_devsel: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    s_claim |=> !devsel_n_o && devsel_oe_o)
    else $error("claimed cycle without device select");
  chk_abort_bound: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    s_unclaimed |=> mst_abort_o)
    else $error("no abort after unclaimed data phase");
  chk_abort_nodev: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    mst_abort_o |-> $past(devsel_n_i) || $past(!stop_n_i))
    else $error("abort while claimed and not stopped");
  chk_done_ready: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    mst_done_o |-> $past(!irdy_n_i) && $past(!trdy_n_i))
    else $error("done without both ready");
  chk_perr_gate: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    !perr_n_o |-> $past(perr_en))
    else $error("parity error driven while disabled");
  chk_serr_pulse: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    serr_en && sys_err_i |=> !serr_n_o)
    else $error("system error not pulsed");
  chk_card_serr: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    !serr_n_o |-> $past(serr_en))
    else $error("system error while disabled");
  chk_card_pulse: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    serr_en && card_addr_perr_i |=> !serr_n_o)
    else $error("card parity error not pulsed");
  chk_req_need: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    !req_n_o |-> $past(pending))
    else $error("request without need");
  chk_start_idle: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    $rose(frame_oe_o) |-> $past(bus_idle) && $past(!gnt_n_i))
    else $error("frame driven on busy bus");
  chk_par_delay: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    par_oe_o && $past(cbe_oe_o) |-> par_o == ^{$past(ad_o), $past(cbe_o)})
    else $error("parity not one clock late");

endmodule // pci_bus_control

// file: pci_host_model.sv
module pci_host_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wire levels
  input wire logic frame_n_i,
  input wire logic irdy_n_i,
  input wire logic req_n_i,
  input wire logic [31:0] ad_i,
  // Scenario: 0 prompt, 1 slow, 2 silent, 3 stop
  input wire logic [1:0] mode_i,
  input wire logic claim_i,
  input wire logic park_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_i,
  // Arbiter and target drives
  output logic gnt_n_o,
  output logic devsel_n_o,
  output logic trdy_n_o,
  output logic stop_n_o,
  output logic resp_oe_o,
  output logic ad_oe_o,
  output logic [31:0] ad_o,
  output logic [31:0] got_o
);
  logic act;
  logic [3:0] cnt;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      {gnt_n_o, devsel_n_o, trdy_n_o, stop_n_o} <= 4'hF;
      {act, resp_oe_o, ad_oe_o} <= 3'h0;
      cnt <= 4'h0;
      ad_o <= 32'h0000_0000;
      got_o <= 32'h0000_0000;
    end else begin
      gnt_n_o <= req_n_i & ~park_i;
      if (!act) begin
        act <= claim_i & ~frame_n_i;
        cnt <= 4'h0;
      end else begin
        cnt <= cnt + 4'h1;
        if (mode_i != 2'h2 && cnt == {3'h0, mode_i == 2'h1}) begin
          devsel_n_o <= 1'h0;
          resp_oe_o <= 1'h1;
        end
        if (mode_i == 2'h3 && cnt == 4'h1) stop_n_o <= 1'h0;
        // Slow mode inserts wait states before ready
        if (mode_i < 2'h2 && cnt == (mode_i == 2'h1 ? 4'h4 : 4'h1)) begin
          trdy_n_o <= 1'h0;
          ad_oe_o <= rd_i;
          ad_o <= rdata_i;
        end
        if (((!trdy_n_o || !stop_n_o) && !irdy_n_i) || cnt == 4'h9) begin
          got_o <= ad_i;
          act <= 1'h0;
          {devsel_n_o, trdy_n_o, stop_n_o} <= 3'h7;
          {resp_oe_o, ad_oe_o} <= 2'h0;
        end
      end
    end
  end
endmodule // pci_host_model

// file: test_pci_bus_control.sv
module test_pci_bus_control;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [2:0] kind;
    logic use_val;
    logic [31:0] val;
  } note_type;
  logic ref_clk_i = 1'h0;
  logic sys_rst_i = 1'h1;
  logic [31:0] ad_o, ad_bus, ad_last, tb_ad, m_ad, m_got, m_rdata, seed;
  logic [31:0] mst_addr_i, mst_wdata_i, mst_rdata_o, tgt_rdata_i, tgt_wdata_o, tgt_addr_o;
  logic [3:0] cbe_o, cbe_bus, cbe_last, tb_cbe, mst_cmd_i, mst_be_n_i, tgt_be_n_o;
  logic [35:0] prev_lines;
  logic [15:0] command_i;
  logic [1:0] m_mode;
  logic ad_oe_o, cbe_oe_o, par_o, par_oe_o, par_bus, par_last, tb_par, tb_par_oe, bad_par;
  logic frame_n_o, frame_oe_o, irdy_n_o, irdy_oe_o, trdy_n_o, trdy_oe_o, prev_oe;
  logic devsel_n_o, devsel_oe_o, stop_n_o, stop_oe_o, perr_n_o, perr_oe_o, serr_n_o, serr_oe_o;
  logic req_n_o, gnt_n, idsel_i, sys_err_i, card_addr_perr_i, mst_start_i;
  logic mst_busy_o, mst_done_o, mst_abort_o, tgt_write_o;
  logic tb_ad_oe, tb_cbe_oe, tb_frame_oe, tb_frame_n, tb_irdy_oe, tb_irdy_n;
  logic m_claim, m_park, m_rd, m_devsel, m_trdy, m_stop, m_oe, m_ad_oe;
  logic frame_bus, irdy_bus, trdy_bus, devsel_bus, stop_bus;
  note_type notes[$];
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;

  always #2 ref_clk_i = ~ref_clk_i;

  // Released lines are pulled up; undriven data shows a changing pattern
  assign frame_bus = frame_oe_o ? frame_n_o : (tb_frame_oe ? tb_frame_n : 1'h1);
  assign irdy_bus = irdy_oe_o ? irdy_n_o : (tb_irdy_oe ? tb_irdy_n : 1'h1);
  assign trdy_bus = trdy_oe_o ? trdy_n_o : (m_oe ? m_trdy : 1'h1);
  assign devsel_bus = devsel_oe_o ? devsel_n_o : (m_oe ? m_devsel : 1'h1);
  assign stop_bus = stop_oe_o ? stop_n_o : (m_oe ? m_stop : 1'h1);
  assign ad_bus = ad_oe_o ? ad_o : (m_ad_oe ? m_ad : (tb_ad_oe ? tb_ad : ~ad_last));
  assign cbe_bus = cbe_oe_o ? cbe_o : (tb_cbe_oe ? tb_cbe : ~cbe_last);
  assign par_bus = par_oe_o ? par_o : (tb_par_oe ? tb_par : ~par_last);

  pci_bus_control uut (
    .ref_clk_i, .sys_rst_i, .ad_i(ad_bus), .ad_o, .ad_oe_o, .cbe_i(cbe_bus), .cbe_o,
    .cbe_oe_o, .par_i(par_bus), .par_o, .par_oe_o, .frame_n_i(frame_bus), .frame_n_o,
    .frame_oe_o, .irdy_n_i(irdy_bus), .irdy_n_o, .irdy_oe_o, .trdy_n_i(trdy_bus),
    .trdy_n_o, .trdy_oe_o, .devsel_n_i(devsel_bus), .devsel_n_o, .devsel_oe_o,
    .stop_n_i(stop_bus), .stop_n_o, .stop_oe_o, .perr_n_o, .perr_oe_o, .serr_n_o,
    .serr_oe_o, .req_n_o, .gnt_n_i(gnt_n), .idsel_i, .command_i, .sys_err_i,
    .card_addr_perr_i, .mst_start_i, .mst_addr_i, .mst_cmd_i, .mst_wdata_i, .mst_be_n_i,
    .mst_busy_o, .mst_done_o, .mst_abort_o, .mst_rdata_o, .tgt_rdata_i, .tgt_write_o,
    .tgt_wdata_o, .tgt_be_n_o, .tgt_addr_o
  );

  pci_host_model host (
    .clk_i(ref_clk_i), .rst_i(sys_rst_i), .frame_n_i(frame_bus), .irdy_n_i(irdy_bus),
    .req_n_i(req_n_o), .ad_i(ad_bus), .mode_i(m_mode), .claim_i(m_claim), .park_i(m_park),
    .rd_i(m_rd), .rdata_i(m_rdata), .gnt_n_o(gnt_n), .devsel_n_o(m_devsel),
    .trdy_n_o(m_trdy), .stop_n_o(m_stop), .resp_oe_o(m_oe), .ad_oe_o(m_ad_oe), .ad_o(m_ad),
    .got_o(m_got)
  );

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic take(logic [2:0] kind, logic [31:0] val);
    note_type n;
    if (notes.size() == 0) begin
      check("stray event", 32'h0000_0000, {29'h0, kind});
    end else begin
      n = notes.pop_front();
      check("event kind", {29'h0, n.kind}, {29'h0, kind});
      if (n.use_val) check("event data", n.val, val);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge ref_clk_i) begin
    ad_last <= ad_bus;
    cbe_last <= cbe_bus;
    par_last <= par_bus;
    tb_par <= ^{ad_bus, cbe_bus} ^ bad_par;
    tb_par_oe <= tb_ad_oe;
    cycles++;
    if (cycles == 6000) begin
      errors++;
      give_verdict();
    end
  end

  always @(posedge ref_clk_i) begin
    #1;
    if (prev_oe && par_oe_o === 1'h1) check("parity", {31'h0, ^prev_lines}, {31'h0, par_o});
    prev_lines = {ad_bus, cbe_bus};
    prev_oe = ad_oe_o & !sys_rst_i;
    if (!sys_rst_i) begin
      if (mst_done_o === 1'h1) take(3'h1, mst_rdata_o);
      if (mst_abort_o === 1'h1) take(3'h2, 32'h0000_0000);
      if (tgt_write_o === 1'h1) take(3'h3, tgt_wdata_o);
      if (perr_oe_o === 1'h1 && perr_n_o === 1'h0) take(3'h4, 32'h0000_0000);
      if (serr_oe_o === 1'h1 && serr_n_o === 1'h0) take(3'h5, 32'h0000_0000);
    end
  end

  task automatic mst(logic [1:0] mode, logic rd);
    logic [31:0] d;
    int n;
    d = rnd();
    n = 0;
    {m_mode, m_rd, m_rdata, m_claim} <= {mode, rd, d, 1'h1};
    mst_addr_i <= d & 32'hFFFF_FFFC;
    mst_cmd_i <= rd ? pci_ctl_pkg::CMD_MEM_READ : pci_ctl_pkg::CMD_MEM_WRITE;
    mst_wdata_i <= d;
    mst_be_n_i <= d[3:0];
    mst_start_i <= 1'h1;
    notes.push_back(mode[1] ? {3'h2, 1'h0, 32'h0000_0000} : {3'h1, rd, d});
    @(posedge ref_clk_i);
    mst_start_i <= 1'h0;
    while (req_n_o !== 1'h0 && n < 4) begin
      @(posedge ref_clk_i);
      n++;
    end
    check("bus request", 32'h0000_0000, {31'h0, req_n_o});
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (mst_busy_o !== 1'h0 && n < 30);
    check("initiator end", 32'h0000_0000, {31'h0, mst_busy_o});
    if (!rd && !mode[1]) check("written word", d, m_got);
    m_claim <= 1'h0;
    // Lets the far side finish its own timeout before the next cycle
    repeat (9) @(posedge ref_clk_i);
  endtask

  task automatic tcyc(logic [3:0] cmd, logic [31:0] addr, logic sel, logic bad, logic claim);
    logic [31:0] d;
    logic hit;
    int n;
    d = rnd();
    hit = 1'h0;
    n = 0;
    @(posedge ref_clk_i);
    {tgt_rdata_i, tb_ad, tb_cbe, idsel_i} <= {d, addr, cmd, sel};
    {tb_frame_oe, tb_frame_n, tb_ad_oe, tb_cbe_oe} <= 4'hB;
    @(posedge ref_clk_i);
    {tb_frame_n, tb_irdy_oe, tb_irdy_n, tb_cbe, idsel_i} <= {3'h6, d[7:4], 1'h0};
    {tb_ad_oe, tb_ad, bad_par} <= {cmd[0], d, bad};
    if (claim && cmd[0]) notes.push_back({3'h3, 1'h1, d});
    if (claim && cmd[0] && bad && command_i[pci_ctl_pkg::PERR_ENABLE_BIT])
      notes.push_back({3'h4, 1'h0, 32'h0000_0000});
    do begin
      @(posedge ref_clk_i);
      n++;
      hit |= (devsel_bus === 1'h0);
    end while (trdy_bus !== 1'h0 && n < 8);
    check("claim", {31'h0, claim}, {31'h0, hit});
    if (claim && !cmd[0]) check("read data", d, ad_bus);
    {tb_irdy_n, tb_frame_oe, tb_ad_oe, tb_cbe_oe, bad_par} <= 5'h10;
    @(posedge ref_clk_i);
    tb_irdy_oe <= 1'h0;
    if (claim) check("target address", addr, tgt_addr_o);
    if (claim) check("byte enables", {28'h0, d[7:4]}, {28'h0, tgt_be_n_o});
    repeat (3) @(posedge ref_clk_i);
  endtask

  initial begin
    seed = 32'h0001_4702;
    {tb_ad_oe, tb_cbe_oe, tb_frame_oe, tb_irdy_oe, m_claim, m_park, m_rd, bad_par} = 8'h00;
    {tb_frame_n, tb_irdy_n, idsel_i, sys_err_i, card_addr_perr_i, mst_start_i} = 6'h30;
    {tb_ad, m_rdata, mst_addr_i, mst_wdata_i, tgt_rdata_i} = 160'h0;
    {tb_cbe, mst_cmd_i, mst_be_n_i, m_mode} = 14'h0;
    {ad_last, cbe_last, par_last, tb_par, tb_par_oe, prev_oe, prev_lines} = 76'h0;
    command_i = 16'h0140;
    repeat (16) @(posedge ref_clk_i);
    sys_rst_i <= 1'h0;
    repeat (2) @(posedge ref_clk_i);
    for (int i = 0; i < 6; i++) mst(i[1:0], i[0] ^ i[2]);
    m_park <= 1'h1;
    repeat (5) @(posedge ref_clk_i);
    #1;
    check("park enable", 32'h0000_0001, {31'h0, ad_oe_o & cbe_oe_o});
    check("park lines", {28'h0, pci_ctl_pkg::BYTE_EN_NONE}, ad_o | {28'h0, cbe_o});
    @(posedge ref_clk_i);
    m_park <= 1'h0;
    repeat (4) @(posedge ref_clk_i);
    tcyc(pci_ctl_pkg::CMD_MEM_WRITE, 32'h0000_0100, 1'h0, 1'h0, 1'h1);
    tcyc(pci_ctl_pkg::CMD_MEM_READ, 32'h0000_0FFC, 1'h0, 1'h0, 1'h1);
    tcyc(pci_ctl_pkg::CMD_MEM_WRITE, 32'h0000_1000, 1'h0, 1'h0, 1'h0);
    tcyc(pci_ctl_pkg::CMD_CFG_WRITE, 32'h0000_0010, 1'h0, 1'h0, 1'h0);
    tcyc(pci_ctl_pkg::CMD_CFG_WRITE, 32'h0000_0010, 1'h1, 1'h0, 1'h1);
    tcyc(pci_ctl_pkg::CMD_CFG_READ, 32'h0000_0014, 1'h1, 1'h0, 1'h1);
    tcyc(pci_ctl_pkg::CMD_MEM_WRITE, 32'h0000_0200, 1'h0, 1'h1, 1'h1);
    command_i <= 16'h0100;
    tcyc(pci_ctl_pkg::CMD_MEM_WRITE, 32'h0000_0204, 1'h0, 1'h1, 1'h1);
    for (int k = 0; k < 4; k++) begin
      command_i <= k[1] ? 16'h0100 : 16'h0000;
      @(posedge ref_clk_i);
      if (k[1]) notes.push_back({3'h5, 1'h0, 32'h0000_0000});
      {sys_err_i, card_addr_perr_i} <= {!k[0], k[0]};
      @(posedge ref_clk_i);
      {sys_err_i, card_addr_perr_i} <= 2'h0;
      repeat (4) @(posedge ref_clk_i);
    end
    repeat (4) @(posedge ref_clk_i);
    check("events left", 32'h0000_0000, notes.size());
    give_verdict();
  end
endmodule // test_pci_bus_control
